// [rtl/rtcal_pkg.sv]
/*
 * rtcal_pkg: register offsets, field positions, reset values, BCD limits
 * and the packed carriers shared by the calendar/alarm block files.
 * Assumes the BCD time counters and the serial bus live outside the block.
 */
package rtcal_pkg;

    // register offsets
    localparam logic [7:0] OFS_CTRL_STATUS = 8'h01;
    localparam logic [7:0] OFS_WEEKDAY = 8'h06;
    localparam logic [7:0] OFS_MONTH = 8'h07;
    localparam logic [7:0] OFS_YEAR = 8'h08;
    localparam logic [7:0] OFS_ALM_MINUTE = 8'h09;
    localparam logic [7:0] OFS_ALM_HOUR = 8'h0a;
    localparam logic [7:0] OFS_ALM_DAY = 8'h0b;
    localparam logic [7:0] OFS_ALM_WEEKDAY = 8'h0c;

    // field positions
    localparam int BIT_MATCH_FLAG = 3;
    localparam int BIT_IRQ_ENABLE = 1;
    localparam int BIT_CENTURY = 7;
    localparam int BIT_CMP_DISABLE = 7;

    // reset values
    localparam logic [2:0] RST_WEEKDAY = 3'h0;
    localparam logic [4:0] RST_MONTH = 5'h01;
    localparam logic RST_CENTURY = 1'b0;
    localparam logic [7:0] RST_YEAR = 8'h00;
    localparam logic RST_CMP_DISABLE = 1'b1;

    // BCD limits
    localparam logic [2:0] WEEKDAY_LAST = 3'h6;
    localparam logic [2:0] WEEKDAY_FIRST = 3'h0;
    localparam logic [4:0] MONTH_JAN = 5'h01;
    localparam logic [4:0] MONTH_FEB = 5'h02;
    localparam logic [4:0] MONTH_APR = 5'h04;
    localparam logic [4:0] MONTH_JUN = 5'h06;
    localparam logic [4:0] MONTH_SEP = 5'h09;
    localparam logic [4:0] MONTH_NOV = 5'h11;
    localparam logic [4:0] MONTH_DEC = 5'h12;
    localparam logic [7:0] YEAR_LAST = 8'h99;
    localparam logic [3:0] BCD_NINE = 4'h9;
    localparam logic [5:0] DAYS_LONG = 6'h31;
    localparam logic [5:0] DAYS_SHORT = 6'h30;
    localparam logic [5:0] DAYS_FEB = 6'h28;
    localparam logic [5:0] DAYS_FEB_LEAP = 6'h29;

    // running time from the external counters
    typedef struct packed {
        logic [6:0] minute;
        logic [5:0] hour;
        logic [5:0] day;
    } rtcal_time_t;

    // register request held across the clock crossing
    typedef struct packed {
        logic write;
        logic [7:0] addr;
        logic [7:0] data;
    } rtcal_req_t;

    // one alarm field: disable bit and compare value
    typedef struct packed {
        logic disable_cmp;
        logic [6:0] value;
    } rtcal_alarm_t;

endpackage

// [rtl/rtcal_sync.sv]
/*
 * rtcal_sync: two-flop synchroniser for levels and toggles.
 * Assumes each bit is an independent level; the destination clock samples it.
 */
`timescale 1ns/1ps
`default_nettype none
module rtcal_sync #(
    parameter int W = 1
) (
    // destination clock
    input wire logic i_clk,
    // asynchronous level in, synchronised level out
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta;

    initial begin
        if (W < 1) begin
            $error("rtcal_sync: W must be at least 1");
        end
    end

    always_ff @(posedge i_clk) begin
        meta <= i_async;
        o_sync <= meta;
    end
endmodule
`default_nettype wire

// [rtl/rtcal_link.sv]
/*
 * rtcal_link: register request port on the link clock; hands each request
 * to the core domain by a toggle handshake and returns read data.
 * Assumes the core holds o_rdata stable once it toggles its acknowledge.
 */
`timescale 1ns/1ps
`default_nettype none
module rtcal_link
    import rtcal_pkg::*;
(
    // link clock and reset
    input wire logic i_link_clk,
    input wire logic i_link_rst,
    // request side
    input wire logic i_req_valid,
    input wire rtcal_req_t i_req,
    output logic o_req_ready,
    output logic o_rsp_valid,
    output logic [7:0] o_rsp_rdata,
    // crossing to the core
    output rtcal_req_t o_xfer,
    output logic o_req_tgl,
    input wire logic i_ack_tgl,
    input wire logic [7:0] i_core_rdata
);
    typedef enum logic [0:0] {RTCAL_IDLE, RTCAL_WAIT} rtcal_link_state_t;
    rtcal_link_state_t state;
    logic ack_sync;

    rtcal_sync #(.W(1)) u_ack_sync (
        .i_clk(i_link_clk),
        .i_async(i_ack_tgl),
        .o_sync(ack_sync)
    );

    always_ff @(posedge i_link_clk) begin
        if (i_link_rst) begin
            state <= RTCAL_IDLE;
            o_req_ready <= 1'b1;
            o_req_tgl <= 1'b0;
            o_xfer <= '0;
        end else begin
            unique case (state)
                RTCAL_IDLE: begin
                    if (i_req_valid) begin
                        o_xfer <= i_req;
                        o_req_tgl <= ~o_req_tgl;
                        o_req_ready <= 1'b0;
                        state <= RTCAL_WAIT;
                    end
                end
                RTCAL_WAIT: begin
                    if (ack_sync == o_req_tgl) begin
                        o_req_ready <= 1'b1;
                        state <= RTCAL_IDLE;
                    end
                end
            endcase
        end
    end

    // answer pulse with read data
    always_ff @(posedge i_link_clk) begin
        if (i_link_rst) begin
            o_rsp_valid <= 1'b0;
            o_rsp_rdata <= 8'h00;
        end else begin
            o_rsp_valid <= (state == RTCAL_WAIT) && (ack_sync == o_req_tgl);
            if ((state == RTCAL_WAIT) && (ack_sync == o_req_tgl)) begin
                o_rsp_rdata <= i_core_rdata;
            end
        end
    end
endmodule
`default_nettype wire

// [rtl/rtcal_top.sv]
/*
 * rtcal_top: weekday, month/century and year registers, the four alarm
 * compare registers and the alarm flag with its interrupt output.
 * Assumes external BCD minute/hour/day counters on I_CLK_SYS that pulse
 * I_TIME_STEP on every update, I_DAY_TICK on every day increment and
 * I_MONTH_END when the day count wraps; the serial bus front end drives
 * the request port on I_LINK_CLK.
 */
// Notes on behaviour
// - weekday held as 3 bits, 0 to 6
// - weekday codes carry no fixed day name
// - year wrap 99 to 00 inverts century
// - century 0 means 20xx, 1 means 19xx
// - month BCD 01 to 12 in bits 4:0
// - year BCD 00 to 99, all bits
// - compare enabled alarm fields with running time
// - flag sets when enabled matches first agree
// - flag stays set until software clears it
// - no re-set while match persists after clear
// - disable bit one makes field always match
// - minute alarm 00-59 in 6:0, disable 7
// - hour alarm 00-23 in 5:0, disable 7
// - day alarm 01-31 in 5:0, disable 7
// - weekday alarm 0-6 in 2:0, disable 7
// - flag write ANDs value into the flag
// - interrupt follows flag only when enabled
// - February gets day 29 when year divisible 4
`timescale 1ns/1ps
`default_nettype none
module rtcal_top
    import rtcal_pkg::*;
(
    // core clock, reset, enable
    input wire logic I_CLK_SYS,
    input wire logic I_SRST,
    input wire logic I_CE,
    // running time from the external counters
    input wire rtcal_time_t I_TIME,
    input wire logic I_TIME_STEP,
    input wire logic I_DAY_TICK,
    input wire logic I_MONTH_END,
    // register request port on the link clock
    input wire logic I_LINK_CLK,
    input wire logic I_REQ_VALID,
    input wire rtcal_req_t I_REQ,
    output logic O_REQ_READY,
    output logic O_RSP_VALID,
    output logic [7:0] O_RSP_RDATA,
    // calendar and alarm outputs
    output logic [5:0] O_MONTH_LAST_DAY,
    output logic O_ALARM_INT
);
    // bcd increment of one digit pair
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        logic [7:0] r;
        r = v;
        if (v[3:0] >= BCD_NINE) begin
            r = {v[7:4] + 4'h1, 4'h0};
        end else begin
            r = {v[7:4], v[3:0] + 4'h1};
        end
        return r;
    endfunction

    // year count divisible by four, year zero included
    function automatic logic leap_year(input logic [7:0] y);
        logic r;
        r = 1'b0;
        if (y[4]) begin
            r = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
        end else begin
            r = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
        end
        return r;
    endfunction

    // one alarm field against running time
    function automatic logic field_match(input rtcal_alarm_t a, input logic [6:0] t);
        return a.disable_cmp || (a.value == t);
    endfunction

    logic link_rst;
    rtcal_req_t xfer;
    logic req_tgl;
    logic req_sync;
    logic req_seen;
    logic ack_tgl;
    logic [7:0] rdata;
    logic [2:0] weekday;
    logic [4:0] month;
    logic century;
    logic [7:0] year;
    rtcal_alarm_t alm_minute;
    rtcal_alarm_t alm_hour;
    rtcal_alarm_t alm_day;
    rtcal_alarm_t alm_weekday;
    logic match_flag;
    logic irq_enable;
    logic match_prev;
    logic req_now;
    logic wr_now;
    logic match_now;
    logic next_match_flag;
    logic [7:0] next_rdata;
    logic [7:0] month_inc;

    // link-side reset and request crossing
    rtcal_sync #(.W(1)) u_rst_sync (
        .i_clk(I_LINK_CLK),
        .i_async(I_SRST),
        .o_sync(link_rst)
    );

    rtcal_link u_link (
        .i_link_clk(I_LINK_CLK),
        .i_link_rst(link_rst),
        .i_req_valid(I_REQ_VALID),
        .i_req(I_REQ),
        .o_req_ready(O_REQ_READY),
        .o_rsp_valid(O_RSP_VALID),
        .o_rsp_rdata(O_RSP_RDATA),
        .o_xfer(xfer),
        .o_req_tgl(req_tgl),
        .i_ack_tgl(ack_tgl),
        .i_core_rdata(rdata)
    );

    rtcal_sync #(.W(1)) u_req_sync (
        .i_clk(I_CLK_SYS),
        .i_async(req_tgl),
        .o_sync(req_sync)
    );

    assign req_now = I_CE && (req_sync != req_seen);
    assign wr_now = req_now && xfer.write;
    assign month_inc = bcd_inc({3'h0, month});

    // handshake acknowledge and read data
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            req_seen <= 1'b0;
            ack_tgl <= 1'b0;
            rdata <= 8'h00;
        end else if (req_now) begin
            req_seen <= req_sync;
            ack_tgl <= req_sync;
            rdata <= next_rdata;
        end
    end

    // read decode, unused bits read zero
    always_comb begin
        next_rdata = 8'h00;
        unique case (xfer.addr)
            OFS_CTRL_STATUS: begin
                next_rdata[BIT_MATCH_FLAG] = match_flag;
                next_rdata[BIT_IRQ_ENABLE] = irq_enable;
            end
            OFS_WEEKDAY: next_rdata = {5'h00, weekday};
            OFS_MONTH: next_rdata = {century, 2'b00, month};
            OFS_YEAR: next_rdata = year;
            OFS_ALM_MINUTE: next_rdata = alm_minute;
            OFS_ALM_HOUR: next_rdata = {alm_hour.disable_cmp, 1'b0, alm_hour.value[5:0]};
            OFS_ALM_DAY: next_rdata = {alm_day.disable_cmp, 1'b0, alm_day.value[5:0]};
            OFS_ALM_WEEKDAY: begin
                next_rdata = {alm_weekday.disable_cmp, 4'h0, alm_weekday.value[2:0]};
            end
            default: next_rdata = 8'h00;
        endcase
    end

    // weekday count, code meaning left to software
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            weekday <= RST_WEEKDAY;
        end else if (I_CE) begin
            if (wr_now && (xfer.addr == OFS_WEEKDAY)) begin
                weekday <= xfer.data[2:0];
            end else if (I_DAY_TICK) begin
                if (weekday >= WEEKDAY_LAST) begin
                    weekday <= WEEKDAY_FIRST;
                end else begin
                    weekday <= weekday + 3'h1;
                end
            end
        end
    end

    // month and century
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            month <= RST_MONTH;
            century <= RST_CENTURY;
        end else if (I_CE) begin
            if (wr_now && (xfer.addr == OFS_MONTH)) begin
                month <= xfer.data[4:0];
                century <= xfer.data[BIT_CENTURY];
            end else if (I_MONTH_END) begin
                if (month == MONTH_DEC) begin
                    month <= MONTH_JAN;
                    if (year == YEAR_LAST) begin
                        century <= ~century;
                    end
                end else begin
                    month <= month_inc[4:0];
                end
            end
        end
    end

    // year
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            year <= RST_YEAR;
        end else if (I_CE) begin
            if (wr_now && (xfer.addr == OFS_YEAR)) begin
                year <= xfer.data;
            end else if (I_MONTH_END && (month == MONTH_DEC)) begin
                if (year == YEAR_LAST) begin
                    year <= 8'h00;
                end else begin
                    year <= bcd_inc(year);
                end
            end
        end
    end

    // alarm compare registers
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            alm_minute <= '{RST_CMP_DISABLE, 7'h00};
            alm_hour <= '{RST_CMP_DISABLE, 7'h00};
            alm_day <= '{RST_CMP_DISABLE, 7'h00};
            alm_weekday <= '{RST_CMP_DISABLE, 7'h00};
        end else if (wr_now) begin
            unique case (xfer.addr)
                OFS_ALM_MINUTE: alm_minute <= xfer.data;
                OFS_ALM_HOUR: alm_hour <= {xfer.data[BIT_CMP_DISABLE], 1'b0, xfer.data[5:0]};
                OFS_ALM_DAY: alm_day <= {xfer.data[BIT_CMP_DISABLE], 1'b0, xfer.data[5:0]};
                OFS_ALM_WEEKDAY: begin
                    alm_weekday <= {xfer.data[BIT_CMP_DISABLE], 4'h0, xfer.data[2:0]};
                end
                default: ;
            endcase
        end
    end

    // all enabled fields agree; disabled fields always match
    assign match_now = field_match(alm_minute, I_TIME.minute)
        && field_match(alm_hour, {1'b0, I_TIME.hour})
        && field_match(alm_day, {1'b0, I_TIME.day})
        && field_match(alm_weekday, {4'h0, weekday});

    // flag: set on a new match at a time step, set wins over clear
    always_comb begin
        next_match_flag = match_flag;
        if (wr_now && (xfer.addr == OFS_CTRL_STATUS)) begin
            next_match_flag = match_flag & xfer.data[BIT_MATCH_FLAG];
        end
        if (I_TIME_STEP && match_now && !match_prev) begin
            next_match_flag = 1'b1;
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            match_flag <= 1'b0;
            match_prev <= 1'b0;
        end else if (I_CE) begin
            match_flag <= next_match_flag;
            if (I_TIME_STEP) begin
                match_prev <= match_now;
            end
        end
    end

    // interrupt enable
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            irq_enable <= 1'b0;
        end else if (wr_now && (xfer.addr == OFS_CTRL_STATUS)) begin
            irq_enable <= xfer.data[BIT_IRQ_ENABLE];
        end
    end

    // interrupt output and month length for the day counter
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            O_ALARM_INT <= 1'b0;
            O_MONTH_LAST_DAY <= DAYS_LONG;
        end else if (I_CE) begin
            O_ALARM_INT <= match_flag && irq_enable;
            if (month == MONTH_FEB) begin
                O_MONTH_LAST_DAY <= leap_year(year) ? DAYS_FEB_LEAP : DAYS_FEB;
            end else if ((month == MONTH_APR) || (month == MONTH_JUN)
                    || (month == MONTH_SEP) || (month == MONTH_NOV)) begin
                O_MONTH_LAST_DAY <= DAYS_SHORT;
            end else begin
                O_MONTH_LAST_DAY <= DAYS_LONG;
            end
        end
    end
endmodule
`default_nettype wire

// [test/rtcal_properties.sv]
/*
 * rtcal_properties: port-level checks of the calendar/alarm block.
 * Bound to rtcal_top; sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
module rtcal_properties (
    // core side
    input wire logic I_CLK_SYS,
    input wire logic I_SRST,
    input wire logic I_TIME_STEP,
    input wire logic I_MONTH_END,
    input wire logic [5:0] O_MONTH_LAST_DAY,
    input wire logic O_ALARM_INT,
    // link side
    input wire logic I_LINK_CLK,
    input wire logic I_REQ_VALID,
    input wire logic O_REQ_READY,
    input wire logic O_RSP_VALID,
    input wire logic [7:0] O_RSP_RDATA
);
    a_int_rise_cause: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
        $rose(O_ALARM_INT) |-> $past(I_TIME_STEP, 2) || !O_REQ_READY)
        else $error("alarm output rose without step or write");
    a_int_fall_cause: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
        $fell(O_ALARM_INT) |-> !O_REQ_READY)
        else $error("alarm output fell without a write");
    a_last_day_set: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
        O_MONTH_LAST_DAY inside {6'h28, 6'h29, 6'h30, 6'h31})
        else $error("last day out of range");
    a_last_day_cause: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
        $changed(O_MONTH_LAST_DAY) |-> $past(I_MONTH_END) || $past(I_MONTH_END, 2)
        || !O_REQ_READY || !$past(O_REQ_READY, 3))
        else $error("last day changed without cause");
    a_take_answer: assert property (@(posedge I_LINK_CLK) disable iff (I_SRST)
        I_REQ_VALID && O_REQ_READY |=> (!O_REQ_READY && !O_RSP_VALID) [*3]
        ##[1:12] O_RSP_VALID)
        else $error("request not answered in time");
    a_rsp_ready: assert property (@(posedge I_LINK_CLK) disable iff (I_SRST)
        O_RSP_VALID |-> O_REQ_READY && !$past(O_REQ_READY))
        else $error("answer without ready rising");
    a_rsp_pulse: assert property (@(posedge I_LINK_CLK) disable iff (I_SRST)
        O_RSP_VALID |=> !O_RSP_VALID)
        else $error("answer longer than one cycle");
    a_rdata_hold: assert property (@(posedge I_LINK_CLK) disable iff (I_SRST)
        $changed(O_RSP_RDATA) |-> O_RSP_VALID)
        else $error("read data changed outside answer");
    c_int_rise: cover property (@(posedge I_CLK_SYS) $rose(O_ALARM_INT));
    c_int_fall: cover property (@(posedge I_CLK_SYS) $fell(O_ALARM_INT));
    c_answer: cover property (@(posedge I_LINK_CLK) O_RSP_VALID);
endmodule
bind rtcal_top rtcal_properties i_props (.I_CLK_SYS(I_CLK_SYS), .I_SRST(I_SRST),
    .I_TIME_STEP(I_TIME_STEP), .I_MONTH_END(I_MONTH_END),
    .O_MONTH_LAST_DAY(O_MONTH_LAST_DAY), .O_ALARM_INT(O_ALARM_INT),
    .I_LINK_CLK(I_LINK_CLK), .I_REQ_VALID(I_REQ_VALID), .O_REQ_READY(O_REQ_READY),
    .O_RSP_VALID(O_RSP_VALID), .O_RSP_RDATA(O_RSP_RDATA));
`default_nettype wire

// [test/rtcal_host.sv]
/*
 * rtcal_host: host side of the register request port.
 * Runs on the link clock; one request outstanding at a time.
 */
`timescale 1ns/1ps
`default_nettype none
module rtcal_host
    import rtcal_pkg::*;
(
    // link clock and handshake
    input wire logic i_clk,
    input wire logic i_ready,
    // request
    output logic o_valid,
    output rtcal_req_t o_req
);
    initial begin
        o_valid = 1'b0;
        o_req = '0;
    end
    // hold until taken, scramble released fields, wait for answer
    task access(input logic wr, input logic [7:0] a, input logic [7:0] d, input int gap);
        repeat (gap) @(posedge i_clk);
        @(posedge i_clk);
        o_valid <= 1'b1;
        o_req <= {wr, a, d};
        @(posedge i_clk);
        while (!i_ready) @(posedge i_clk);
        o_valid <= 1'b0;
        o_req <= ~o_req;
        @(posedge i_clk);
        while (!i_ready) @(posedge i_clk);
    endtask
endmodule
`default_nettype wire

// [test/rtc_calendar_alarm_compare_tb.sv]
/*
 * rtc_calendar_alarm_compare_tb: self-checking bench for rtcal_top.
 * Assumes the host model on the link side and time pulses from the bench.
 */
`timescale 1ns/1ps
`default_nettype none
module rtc_calendar_alarm_compare_tb;
    import rtcal_pkg::*;
    logic clk = 1'b0;
    logic lclk = 1'b0;
    logic srst = 1'b1;
    rtcal_time_t tm = '0;
    logic step = 1'b0;
    logic day = 1'b0;
    logic mend = 1'b0;
    logic ce = 1'b1;
    logic rvalid, ready, rsp, irq;
    rtcal_req_t req;
    logic [7:0] rdata, v;
    logic [5:0] last_day;
    logic [8:0] n;
    logic [8:0] expq [$];
    logic [7:0] msk [7] = '{8'h07, 8'h9f, 8'hff, 8'hff, 8'hbf, 8'hbf, 8'h87};
    logic [23:0] tbl [5] = '{24'h020029, 24'h020328, 24'h029629, 24'h110330, 24'h010331};
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    int seed = 32'haed6;
    always #12.5 clk = ~clk;
    always #16 lclk = ~lclk;
    rtcal_top i_dut (.I_CLK_SYS(clk), .I_SRST(srst), .I_CE(ce), .I_TIME(tm),
        .I_TIME_STEP(step), .I_DAY_TICK(day), .I_MONTH_END(mend), .I_LINK_CLK(lclk),
        .I_REQ_VALID(rvalid), .I_REQ(req), .O_REQ_READY(ready), .O_RSP_VALID(rsp),
        .O_RSP_RDATA(rdata), .O_MONTH_LAST_DAY(last_day), .O_ALARM_INT(irq));
    rtcal_host i_host (.i_clk(lclk), .i_ready(ready), .o_valid(rvalid), .o_req(req));
    task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s exp %h seen %h", name, exp, seen);
        end
    endtask
    task results;
        if (fail_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        expq.push_back({1'b0, 8'h00});
        i_host.access(1'b1, a, d, $random(seed) & 3);
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        expq.push_back({1'b1, e});
        i_host.access(1'b0, a, 8'h00, $random(seed) & 3);
    endtask
    task cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    task tick(input logic m);
        @(negedge clk);
        day = 1'b1;
        mend = m;
        @(negedge clk);
        day = 1'b0;
        mend = 1'b0;
    endtask
    task stp(input logic [6:0] mi, input logic [5:0] h, input logic [7:0] e);
        @(negedge clk);
        tm = {mi, h, 6'h01};
        step = 1'b1;
        @(negedge clk);
        step = 1'b0;
        cyc(2);
        check("irq", {7'h00, irq}, e);
    endtask
    // answers are matched against the oldest note
    always @(posedge lclk) begin
        if (rsp === 1'b1) begin
            n = (expq.size() > 0) ? expq.pop_front() : 9'h1ff;
            if (n[8]) check("rdata", rdata, n[7:0]);
        end
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            fail_count++;
            results();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        @(negedge clk);
        srst = 1'b0;
        cyc(6);
        rd(OFS_WEEKDAY, 8'h00);
        rd(OFS_MONTH, 8'h01);
        rd(OFS_YEAR, 8'h00);
        rd(OFS_CTRL_STATUS, 8'h00);
        rd(8'h20, 8'h00);
        for (int i = 0; i < 7; i++) begin
            rd(8'(OFS_WEEKDAY + i), (i > 2) ? 8'h80 : ((i == 1) ? 8'h01 : 8'h00));
            v = $random(seed);
            wr(8'(OFS_WEEKDAY + i), v);
            rd(8'(OFS_WEEKDAY + i), v & msk[i]);
        end
        wr(OFS_WEEKDAY, 8'h06);
        wr(OFS_MONTH, 8'h12);
        wr(OFS_YEAR, 8'h99);
        tick(1'b1);
        rd(OFS_WEEKDAY, 8'h00);
        rd(OFS_MONTH, 8'h81);
        rd(OFS_YEAR, 8'h00);
        wr(OFS_MONTH, 8'h09);
        tick(1'b1);
        tick(1'b0);
        rd(OFS_MONTH, 8'h10);
        rd(OFS_WEEKDAY, 8'h02);
        for (int i = 0; i < 5; i++) begin
            wr(OFS_MONTH, tbl[i][23:16]);
            wr(OFS_YEAR, tbl[i][15:8]);
            cyc(4);
            check("last_day", {2'b00, last_day}, tbl[i][7:0]);
        end
        wr(OFS_ALM_MINUTE, 8'h15);
        wr(OFS_ALM_HOUR, 8'h07);
        wr(OFS_ALM_DAY, 8'h80);
        wr(OFS_ALM_WEEKDAY, 8'h80);
        wr(OFS_CTRL_STATUS, 8'h02);
        stp(7'h15, 6'h08, 8'h00);
        stp(7'h15, 6'h07, 8'h01);
        wr(OFS_CTRL_STATUS, 8'h0a);
        rd(OFS_CTRL_STATUS, 8'h0a);
        wr(OFS_CTRL_STATUS, 8'h02);
        cyc(2);
        check("irq", {7'h00, irq}, 8'h00);
        stp(7'h15, 6'h07, 8'h00);
        stp(7'h16, 6'h07, 8'h00);
        stp(7'h15, 6'h07, 8'h01);
        wr(OFS_CTRL_STATUS, 8'h08);
        cyc(2);
        check("irq", {7'h00, irq}, 8'h00);
        rd(OFS_CTRL_STATUS, 8'h08);
        wr(OFS_ALM_WEEKDAY, 8'h03);
        wr(OFS_CTRL_STATUS, 8'h02);
        stp(7'h16, 6'h07, 8'h00);
        stp(7'h15, 6'h07, 8'h00);
        tick(1'b0);
        stp(7'h15, 6'h07, 8'h01);
        ce = 1'b0;
        tick(1'b1);
        ce = 1'b1;
        rd(OFS_WEEKDAY, 8'h03);
        rd(OFS_MONTH, 8'h01);
        cyc(4);
        results();
    end
endmodule
`default_nettype wire
